// ---- rtl/peak_code_tracker.sv ----
/*
  Peak code tracker: per-channel maximum capture for channels 1 to 4 with
  clear-on-read byte registers behind an AXI4-Lite slave.
  Assumes conversion results arrive synchronous to aclk, one per cycle at
  most, and that the master keeps to AXI4-Lite handshakes.
*/
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module peak_code_tracker (
  // Clock and reset.
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Conversion results.
  input  wire peak_pkg::conv_t             conv,
  // AXI4-Lite write address and data.
  input  wire logic [peak_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // AXI4-Lite write response.
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // AXI4-Lite read.
  input  wire logic [peak_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready
);

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [peak_pkg::CODE_W-1:0] peak_r   [0:peak_pkg::SLOTS-1];  // Held maxima.
  logic [peak_pkg::HIGH_W-1:0] shadow_r [0:peak_pkg::HSLOTS-1]; // High byte kept at low read.
  logic                        pend_r   [0:peak_pkg::HSLOTS-1]; // Shadow holds a value.
  logic [peak_pkg::SLOTS-1:0]  hit;       // Result for this slot this cycle.
  logic [peak_pkg::SLOTS-1:0]  clr_low;   // Low byte read taken this cycle.
  logic [peak_pkg::HSLOTS-1:0] clr_high;  // High byte read taken this cycle.
  logic                        track_en_r; // Tracking enable, software controlled.
  logic                        awready_r;  // Write address may be taken.
  logic                        wready_r;   // Write data may be taken.
  logic                        bvalid_r;   // Write response pending.
  logic [1:0]                  bresp_r;    // Write response code.
  logic                        arready_r;  // Read address may be taken.
  logic                        rvalid_r;   // Read answer pending.
  logic [31:0]                 rdata_r;    // Read answer data.
  logic [1:0]                  rresp_r;    // Read answer code.
  logic                        aw_held_r;  // Write address captured.
  logic                        w_held_r;   // Write data captured.
  logic [peak_pkg::IDX_W-1:0]  wr_idx_r;   // Captured write index.
  logic [31:0]                 wdata_r;    // Captured write data.
  logic [3:0]                  wstrb_r;    // Captured write strobes.
  logic                        wr_go;      // Write commits this cycle.
  logic                        rd_go;      // Read address taken this cycle.
  logic [peak_pkg::IDX_W-1:0]  rd_idx;
  logic [31:0]                 rd_val;     // Read data selected.
  logic                        rd_hit;     // Read address is mapped.
  logic                        wr_hit;     // Write address is mapped.

  // Every output comes straight from its flip-flop.
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Read index and the strobes that start a read or commit a write.
  assign rd_idx = araddr[peak_pkg::ADDR_W-1:2];
  assign rd_go  = arvalid && arready_r;
  assign wr_go  = aw_held_r && w_held_r && !bvalid_r;

  // ****************************************************************
  // Peak capture per channel.
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < peak_pkg::SLOTS; gi++) begin : g_slot
      // A result counts only for its own channel and while tracking is on.
      assign hit[gi]     = conv.valid && track_en_r && (conv.chan == peak_pkg::SLOT_CHAN[gi]);
      assign clr_low[gi] = rd_go && (rd_idx == peak_pkg::LOW_IDX[gi]);

      // Peak update; a clearing read restarts from the colliding result.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          peak_r[gi] <= peak_pkg::PEAK_RESET;
        end else if (clr_low[gi] || ((gi < peak_pkg::HSLOTS) && clr_high[gi % peak_pkg::HSLOTS]
                                     && !pend_r[gi % peak_pkg::HSLOTS])) begin
          peak_r[gi] <= hit[gi] ? conv.code : peak_pkg::PEAK_RESET;
        end else if (hit[gi] && (conv.code > peak_r[gi])) begin
          peak_r[gi] <= conv.code;
        end
      end

      // Capture and clear-on-read checks.
      a_peak_rises: assert property (@(posedge aclk) disable iff (!aresetn)
        hit[gi] && !clr_low[gi] && (conv.code > peak_r[gi]) |=> peak_r[gi] == $past(conv.code))
        else $error("peak did not take a larger code");
      a_peak_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !hit[gi] && !rd_go |=> $stable(peak_r[gi]))
        else $error("peak changed without a result or read");
      a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_low[gi] && !hit[gi] |=> peak_r[gi] == peak_pkg::PEAK_RESET)
        else $error("low byte read did not clear peak");
      a_read_returns: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_low[gi] |=> rvalid_r && (rdata_r[peak_pkg::LOW_MSB:peak_pkg::LOW_LSB] ==
          $past(peak_r[gi][peak_pkg::LOW_MSB:peak_pkg::LOW_LSB])))
        else $error("low byte read returned wrong value");
      a_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> peak_r[gi] == peak_pkg::PEAK_RESET)
        else $error("peak not zero after reset");
      a_keep_collision: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_low[gi] && hit[gi] |=> peak_r[gi] == $past(conv.code))
        else $error("result lost during clearing read");
      a_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && !hit[gi] && !rd_go |=> $stable(peak_r[gi]))
        else $error("write altered a peak");
    end

    for (gi = 0; gi < peak_pkg::HSLOTS; gi++) begin : g_high
      assign clr_high[gi] = rd_go && (rd_idx == peak_pkg::HIGH_IDX[gi]);

      // A low byte read keeps the high byte so the pair reads consistently.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          shadow_r[gi] <= peak_pkg::SHADOW_RESET;
          pend_r[gi]   <= 1'b0;
        end else if (clr_low[gi]) begin
          shadow_r[gi] <= peak_r[gi][peak_pkg::HIGH_MSB:peak_pkg::HIGH_LSB];
          pend_r[gi]   <= 1'b1;
        end else if (clr_high[gi]) begin
          shadow_r[gi] <= peak_pkg::SHADOW_RESET;
          pend_r[gi]   <= 1'b0;
        end
      end

      a_high_pairs: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_low[gi] ##1 (!rd_go [*1]) ##0 (clr_high[gi] == 1'b0) ##[0:4] clr_high[gi]
        |=> rdata_r[peak_pkg::HIGH_W-1:0] == $past(shadow_r[gi]))
        else $error("high byte lost its pair value");

      // A high byte read with nothing saved answers live and clears.
      a_high_live: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_high[gi] && !pend_r[gi] |=> rdata_r[peak_pkg::HIGH_W-1:0] ==
          $past(peak_r[gi][peak_pkg::HIGH_MSB:peak_pkg::HIGH_LSB]))
        else $error("high byte read returned wrong value");
      a_high_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        clr_high[gi] && !pend_r[gi] && !hit[gi] |=> peak_r[gi] == peak_pkg::PEAK_RESET)
        else $error("high byte read did not clear peak");
    end
  endgenerate

  // ****************************************************************
  // Read decode and data select.
  // ****************************************************************
  // Selects the addressed byte; narrow data sits in the low bits.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    if (rd_idx == peak_pkg::TRACK_CTRL_IDX) begin
      rd_hit = 1'b1;
      rd_val[peak_pkg::TRACK_EN_BIT] = track_en_r;
    end
    for (int i = 0; i < peak_pkg::SLOTS; i++) begin
      if (rd_idx == peak_pkg::LOW_IDX[i]) begin
        rd_hit = 1'b1;
        rd_val[peak_pkg::LOW_MSB:peak_pkg::LOW_LSB] =
          peak_r[i][peak_pkg::LOW_MSB:peak_pkg::LOW_LSB];
      end
    end
    for (int i = 0; i < peak_pkg::HSLOTS; i++) begin
      if (rd_idx == peak_pkg::HIGH_IDX[i]) begin
        rd_hit = 1'b1;
        rd_val[peak_pkg::HIGH_W-1:0] = pend_r[i] ? shadow_r[i]
                                : peak_r[i][peak_pkg::HIGH_MSB:peak_pkg::HIGH_LSB];
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  // Accepts one address at a time; data follows one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= !rd_go && (!rvalid_r || rready);
    end
  end

  // Registers the answer and holds it until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= peak_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? peak_pkg::RESP_OKAY : peak_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Unmapped reads answer an error with zero data.
  a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && !rd_hit |=> rvalid_r && (rresp_r == peak_pkg::RESP_SLVERR)
      && (rdata_r == 32'h0000_0000))
    else $error("unmapped read not refused");

  // ****************************************************************
  // AXI4-Lite write channels.
  // ****************************************************************
  // Address and data are captured independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      wr_idx_r  <= '0;
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      wr_idx_r  <= awaddr[peak_pkg::ADDR_W-1:2];
    end else begin
      if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      awready_r <= !aw_held_r;
    end
  end

  // Write data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else begin
      if (wr_go) begin
        w_held_r <= 1'b0;
      end
      wready_r <= !w_held_r;
    end
  end

  // Peak bytes accept a write but keep their value; only the control word stores.
  assign wr_hit = (wr_idx_r == peak_pkg::TRACK_CTRL_IDX) ||
                  (wr_idx_r >= peak_pkg::CHAN1_PEAK_LOW_IDX &&
                   wr_idx_r <= peak_pkg::CHAN4_PEAK_LOW_IDX);

  // Control register store, byte lane 0 only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      track_en_r <= peak_pkg::TRACK_EN_RESET;
    end else if (wr_go && wstrb_r[0] && (wr_idx_r == peak_pkg::TRACK_CTRL_IDX)) begin
      track_en_r <= wdata_r[peak_pkg::TRACK_EN_BIT];
    end
  end

  // Only the control index stores; writes to peak bytes leave all state alone.
  a_ctrl_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_go && (wr_idx_r == peak_pkg::TRACK_CTRL_IDX)) |=> $stable(track_en_r))
    else $error("enable changed without a control write");

  // Write response follows both halves.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= peak_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? peak_pkg::RESP_OKAY : peak_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Write steps: both halves taken, then a response two edges later.
  sequence s_both_taken;
    awvalid && awready_r && wvalid && wready_r;
  endsequence
  sequence s_resp_up;
    ##1 wr_go ##1 bvalid_r;
  endsequence
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_both_taken |-> s_resp_up)
    else $error("write response not after two edges");

endmodule : peak_code_tracker

// ---- rtl/peak_pkg.sv ----
/*
  Constants and carrier types for the peak code tracker: register indices,
  field layout, reset values and the conversion result carrier.
  Assumes a 12-bit converter that reports one result at a time with its
  channel number, and an AXI4-Lite master with 32-bit data.
*/
package peak_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int CODE_W  = 12;  // Converter result width.
  localparam int CHAN_W  = 3;   // Physical channel number width.
  localparam int IDX_W   = 10;  // Register index width (byte address / 4).
  localparam int ADDR_W  = 12;  // AXI address width.
  localparam int SLOTS   = 4;   // Tracked channels 1 to 4.
  localparam int HSLOTS  = 3;   // Channels with a high byte in this block.

  // ****************************************************************
  // Register indices; byte address is four times the index.
  // ****************************************************************
  localparam logic [IDX_W-1:0] CHAN1_PEAK_LOW_IDX  = 10'h062;
  localparam logic [IDX_W-1:0] CHAN1_PEAK_HIGH_IDX = 10'h063;
  localparam logic [IDX_W-1:0] CHAN2_PEAK_LOW_IDX  = 10'h064;
  localparam logic [IDX_W-1:0] CHAN2_PEAK_HIGH_IDX = 10'h065;
  localparam logic [IDX_W-1:0] CHAN3_PEAK_LOW_IDX  = 10'h066;
  localparam logic [IDX_W-1:0] CHAN3_PEAK_HIGH_IDX = 10'h067;
  localparam logic [IDX_W-1:0] CHAN4_PEAK_LOW_IDX  = 10'h068;
  localparam logic [IDX_W-1:0] TRACK_CTRL_IDX      = 10'h070;

  // Index tables in slot order, slot 0 is channel 1.
  localparam logic [IDX_W-1:0] LOW_IDX [0:SLOTS-1] = '{
    CHAN1_PEAK_LOW_IDX, CHAN2_PEAK_LOW_IDX, CHAN3_PEAK_LOW_IDX, CHAN4_PEAK_LOW_IDX};
  localparam logic [IDX_W-1:0] HIGH_IDX [0:HSLOTS-1] = '{
    CHAN1_PEAK_HIGH_IDX, CHAN2_PEAK_HIGH_IDX, CHAN3_PEAK_HIGH_IDX};
  localparam logic [CHAN_W-1:0] SLOT_CHAN [0:SLOTS-1] = '{3'h1, 3'h2, 3'h3, 3'h4};

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************
  localparam int LOW_LSB  = 0;   // Low byte holds code bits 7:0.
  localparam int LOW_MSB  = 7;
  localparam int HIGH_LSB = 8;   // High byte holds code bits 11:8 in its low nibble.
  localparam int HIGH_MSB = 11;
  localparam int HIGH_W   = 4;
  localparam logic [CODE_W-1:0] PEAK_RESET  = 12'h000;
  localparam logic [HIGH_W-1:0] SHADOW_RESET = 4'h0;
  localparam logic              TRACK_EN_RESET = 1'b1;
  localparam int                TRACK_EN_BIT   = 0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One conversion result as it leaves the converter.
  typedef struct packed {
    logic              valid;  // High for one cycle with a new result.
    logic [CHAN_W-1:0] chan;   // Channel that was converted.
    logic [CODE_W-1:0] code;   // Conversion code.
  } conv_t;

endpackage : peak_pkg

// ---- test/peak_code_tracker_test.sv ----
/*
  Self-checking bench for the peak code tracker: an integer model of the
  peak, shadow and enable state is compared with every AXI4-Lite answer.
  Assumes a slave that answers within the bench's wait limits and a 100 MHz clock.
*/
`timescale 1ns/1ps
module peak_code_tracker_test;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic                        aclk;     // Bench clock.
  logic                        aresetn;  // Synchronous reset, active low.
  peak_pkg::conv_t             conv;     // Conversion results.
  logic [peak_pkg::ADDR_W-1:0] awaddr;   // Write address.
  logic                        awvalid;  // Write address valid.
  logic                        awready;  // Write address ready.
  logic [31:0]                 wdata;    // Write data.
  logic [3:0]                  wstrb;    // Write strobes.
  logic                        wvalid;   // Write data valid.
  logic                        wready;   // Write data ready.
  logic [1:0]                  bresp;    // Write response.
  logic                        bvalid;   // Write response valid.
  logic                        bready;   // Write response ready.
  logic [peak_pkg::ADDR_W-1:0] araddr;   // Read address.
  logic                        arvalid;  // Read address valid.
  logic                        arready;  // Read address ready.
  logic [31:0]                 rdata;    // Read data.
  logic [1:0]                  rresp;    // Read response.
  logic                        rvalid;   // Read data valid.
  logic                        rready;   // Read data ready.
  int                          fail_count = 0;  // Mismatches seen.
  int                          num_checks = 0;  // Comparisons made.
  int                          pk [1:4];  // Model peak per channel.
  int                          sh [1:4];  // Model saved high nibble.
  bit                          shv [1:4]; // Model saved nibble pending.
  bit                          en;        // Model tracking enable.

  peak_code_tracker dut (.aclk(aclk), .aresetn(aresetn), .conv(conv),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // The clock toggles every half period of 5 ns.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************************************************************
  // Model and bus tasks.
  // ****************************************************************
  // Prints the counts and the verdict, then stops the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // A used-up wait counts as a mismatch and ends the run.
  task automatic give_up();
    fail_count++;
    close_out();
  endtask : give_up

  // Applies one conversion result to the model.
  task automatic mconv(input peak_pkg::conv_t c);
    if (c.valid && en && c.chan >= 1 && c.chan <= 4 && int'(c.code) > pk[c.chan])
      pk[c.chan] = int'(c.code);
  endtask : mconv

  // Predicts a read answer and applies its clearing side effect.
  task automatic mread(input int idx, output logic [31:0] e, output logic [1:0] r);
    int c;
    e = 32'h0000_0000;
    r = peak_pkg::RESP_OKAY;
    c = (idx - 'h62) / 2 + 1;
    if (idx == 'h70) e = {31'h0000_0000, en};
    else if (idx < 'h62 || idx > 'h68) r = peak_pkg::RESP_SLVERR;
    else if ((idx - 'h62) % 2 == 0) begin
      // Low byte: hand out bits 7:0, keep the nibble for channels 1 to 3, clear the peak.
      e = pk[c] & 'hff;
      if (c < 4) begin
        sh[c] = pk[c] >> 8;
        shv[c] = 1'b1;
      end
      pk[c] = 0;
    end else if (shv[c]) begin
      e = sh[c];
      shv[c] = 1'b0;
    end else begin
      e = pk[c] >> 8;
      pk[c] = 0;
    end
  endtask : mread

  // Sends one conversion result as a single-cycle pulse.
  task automatic send(input int ch, input int code);
    @(posedge aclk);
    conv <= '{1'b1, 3'(ch), 12'(code)};
    mconv('{1'b1, 3'(ch), 12'(code)});
    @(posedge aclk);
    conv <= '0;
  endtask : send

  // Reads one register, optionally with a conversion on the taking edge.
  task automatic rd(input int idx, input peak_pkg::conv_t cv);
    logic [31:0] e;
    logic [1:0]  r;
    int          n;
    mread(idx, e, r);
    mconv(cv);
    @(posedge aclk);
    araddr <= 12'(idx * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    conv <= cv;
    n = 0;
    do begin
      @(posedge aclk);
      conv <= '0;
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    rready <= 1'b0;
    if (n >= 200) give_up();
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, r});
  endtask : rd

  // Writes one register; address and data are released as each is taken.
  task automatic wr(input int idx, input logic [31:0] d);
    logic [1:0] r;
    int         n;
    bit         a;
    bit         w;
    r = ((idx >= 'h62 && idx <= 'h68) || idx == 'h70) ? peak_pkg::RESP_OKAY
                                                       : peak_pkg::RESP_SLVERR;
    if (idx == 'h70) en = d[0];
    @(posedge aclk);
    awaddr <= 12'(idx * 4);
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {a, w, n} = '0;
    while (!(a && w) && n < 100) begin
      @(posedge aclk);
      n++;
      // Each half is released at the edge at which it was taken.
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    bready <= 1'b0;
    if (n >= 200) give_up();
    check({30'h0, bresp}, {30'h0, r});
  endtask : wr

  // Holds reset for 16 cycles and clears the model to its reset state.
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (pk[i]) begin
      pk[i] = 0;
      shv[i] = 1'b0;
    end
    en = 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {conv, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    void'($urandom(21));
    do_reset();
    for (int i = 'h62; i <= 'h68; i++) rd(i, '0);
    rd('h70, '0);
    // Random results on all channels, ignored ones included, with reads.
    repeat (80) begin
      send($urandom_range(0, 7), $urandom_range(0, 4095));
      if ($urandom_range(0, 2) == 0) rd($urandom_range('h62, 'h68), '0);
    end
    // Writes to peak bytes are ignored, then two passes show the clear.
    for (int i = 'h62; i <= 'h68; i++) wr(i, $urandom());
    repeat (2) for (int i = 'h62; i <= 'h68; i++) rd(i, '0);
    wr('h10, 32'h0000_00a5);
    rd('h10, '0);
    // A result that meets a clearing read becomes the new peak.
    send(4, 'h3c7);
    rd('h68, '{1'b1, 3'h4, 12'h0e1});
    rd('h68, '0);
    // Frozen tracking keeps the peak still.
    wr('h70, 32'h0000_0000);
    rd('h70, '0);
    send(2, 'habc);
    rd('h64, '0);
    wr('h70, 32'h0000_0001);
    send(2, 'h9f2);
    rd('h65, '0);
    rd('h64, '0);
    // A reset in mid-run drops a held peak.
    send(1, 'hfff);
    do_reset();
    rd('h62, '0);
    rd('h63, '0);
    close_out();
  end
endmodule : peak_code_tracker_test
